// [design/srx_top.sv]
/*
  Serial interface with receiver muting, idle/address wake-up, byte parity,
  status flags with sequence clears, low-power mode handling and a shared interrupt.
  Assumes an APB master on pclk, and rx line synchronous to pclk.
*/
// Functional notes
// - While muted, no receive flag sets and receive interrupts stay quiet.
// - Muted receiver wakes on idle line or address mark per wake select.
// - Idle-line wake clears mute bit without setting the idle flag.
// - Address mark (data MSB one) clears mute and sets rx full flag.
// - Address mark looks at data MSB, never the parity bit.
// - Frame is start, payload, stop; payload 8 or 9 bits, parity taking last.
// - Even parity makes ones count of low data bits plus parity even.
// - Odd parity makes that ones count odd.
// - With parity on, transmitter sends parity instead of payload MSB.
// - Parity failure sets parity flag, interrupting when its enable is set.
// - Wait mode keeps operating; enabled interrupt requests wake from wait.
// - Halt stops transfers, freezes registers, never wakes the device.
// - All events except noise and framing fault share one interrupt, each gated by enable and global mask.
// - Tx empty sets on transfer to shifter, clears by status then data write.
// - Tx done sets after data characters only, clears by status then write.
// - Rx full sets on new word; receive flags clear by status then data read.
// - Idle flag sets on idle line, not again until a new word arrives.
// - Overrun keeps holding buffer, overwrites shifter, sets overrun flag.
// - Noise flag sets with rx full and has no interrupt of its own.
// - Framing fault without own interrupt; overrun hides framing fault.
// - Status reads C0 after reset.
// - Long word bit selects eight or nine data bits between start and stop.
// - With address-mark wake, software cannot change mute while rx full set.
`timescale 1ns/1ps
module srx_top
  import srx_pkg::*;
#(
  parameter int OVS_DIV = 4
) (
  // APB clock and reset
  input  wire logic        pclk,
  input  wire logic        presetn,
  // APB slave
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [7:0]  paddr,
  input  wire logic [31:0] pwdata,
  output logic [31:0]      prdata,
  output logic             pready,
  output logic             pslverr,
  // Serial line
  input  wire logic        rx_line,
  output logic             tx_line,
  // Interrupt and wake towards the CPU
  output logic             irq_r,
  output logic             wake_r
);
  if (OVS_DIV < 1 || OVS_DIV > 256) $error("OVS_DIV out of range");

  ////////////////////////////////////////////////////////////////////////
  // Registers
  logic [7:0] status_r, ctrl1_r, ctrl2_r, baud_r;
  logic [2:0] sys_r;
  logic [8:0] rx_hold_r, tx_hold_r;
  logic       tx_pend_r;
  logic       st_seen_r;   // Status read armed the clear sequence
  logic [7:0] st_snap_r;   // Flags as seen by that read
  logic       idle_arm_r;  // Idle flag allowed to set again

  wire halt    = sys_r[SRX_SY_HALT];
  wire long_w  = ctrl1_r[SRX_C1_LONG];
  wire par_en  = ctrl1_r[SRX_C1_PCE];
  wire par_odd = ctrl1_r[SRX_C1_PS];
  wire muted   = ctrl2_r[SRX_C2_RWU];

  wire acc    = psel && penable && !halt;  // Halt freezes the register file
  wire wr     = acc && pwrite;
  wire rd     = acc && !pwrite;
  wire st_rd  = rd && paddr == SRX_OFF_STATUS;
  wire dat_rd = rd && paddr == SRX_OFF_DATA;
  wire dat_wr = wr && paddr == SRX_OFF_DATA;

  // Parity over the 7 or 8 low data bits
  function automatic logic par_of(input logic [8:0] d, input logic lw, input logic odd);
    logic p;
    p = lw ? ^d[7:0] : ^d[6:0];
    return p ^ odd;
  endfunction : par_of

  ////////////////////////////////////////////////////////////////////////
  // Oversampling tick: 16 per bit
  logic [7:0] div_r;
  logic       tick;
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      div_r <= 8'h00;
    end else if (!halt) begin
      div_r <= (div_r >= 8'(OVS_DIV - 1)) ? 8'h00 : div_r + 8'h01;
    end
  end
  assign tick = !halt && div_r == 8'h00;  // Halt stops both directions

  ////////////////////////////////////////////////////////////////////////
  // Receiver
  srx_state_e rx_st_r;
  logic [3:0] rx_ovs_r, rx_bit_r;
  logic [8:0] rx_sh_r;
  logic [2:0] rx_smp_r;
  logic       rx_noise_r;
  logic [3:0] idle_cnt_r;
  logic       rx_done, idle_det;
  srx_word_s  rx_w;
  wire [3:0]  nbits = long_w ? 4'h9 : 4'h8;
  wire        rx_en = ctrl2_r[SRX_C2_RE];

  // Majority sampling around mid bit; disagreement is noise
  wire maj   = (rx_smp_r[0] & rx_smp_r[1]) | (rx_smp_r[1] & rx_smp_r[2]) | (rx_smp_r[0] & rx_smp_r[2]);
  wire disag = !(&rx_smp_r) && (|rx_smp_r);

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      rx_st_r    <= SRX_IDLE;
      rx_ovs_r   <= 4'h0;
      rx_bit_r   <= 4'h0;
      rx_sh_r    <= 9'h000;
      rx_smp_r   <= 3'h7;
      rx_noise_r <= 1'b0;
    end else if (tick) begin
      rx_smp_r <= {rx_smp_r[1:0], rx_line};
      rx_ovs_r <= rx_ovs_r + 4'h1;
      case (rx_st_r)
        SRX_IDLE: begin
          if (rx_en && !rx_line) begin  // Phase runs free in idle to time the quiet line
            rx_ovs_r   <= 4'h0;
            rx_st_r    <= SRX_START;
            rx_noise_r <= 1'b0;
            rx_bit_r   <= 4'h0;
          end
        end
        SRX_START: if (rx_ovs_r == SRX_OVS_MID + 4'h1) begin
          if (maj) rx_st_r <= SRX_IDLE;  // False start
          rx_noise_r <= disag;
        end else if (rx_ovs_r == SRX_OVS_LAST) begin
          rx_st_r <= SRX_DATA;
        end
        SRX_DATA: if (rx_ovs_r == SRX_OVS_MID + 4'h1) begin
          rx_sh_r    <= long_w ? {maj, rx_sh_r[8:1]} : {1'b0, maj, rx_sh_r[7:1]};  // LSB first
          rx_noise_r <= rx_noise_r | disag;
          rx_bit_r   <= rx_bit_r + 4'h1;
        end else if (rx_ovs_r == SRX_OVS_LAST && rx_bit_r == nbits) begin
          rx_st_r <= SRX_STOP;
        end
        SRX_STOP: if (rx_ovs_r == SRX_OVS_MID + 4'h1) begin
          rx_st_r <= SRX_IDLE;
        end
        default: rx_st_r <= SRX_IDLE;
      endcase
    end
  end
  assign rx_done = tick && rx_st_r == SRX_STOP && rx_ovs_r == SRX_OVS_MID + 4'h1;

  // Word as completed: stop bit low is a framing fault or break
  always_comb begin
    rx_w           = '0;
    rx_w.data      = rx_sh_r;
    rx_w.noise     = rx_noise_r | disag;
    rx_w.frame_err = !maj;
    rx_w.par_err   = par_en && (par_of(rx_sh_r, long_w, par_odd) != (long_w ? rx_sh_r[8] : rx_sh_r[7]));
  end

  // Idle line: a full character time of ones, 10 or 11 bits
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      idle_cnt_r <= 4'h0;
    end else if (tick && rx_ovs_r == SRX_OVS_LAST) begin
      if (!rx_en || rx_st_r != SRX_IDLE || !rx_line) idle_cnt_r <= 4'h0;
      else if (idle_cnt_r != 4'hF) idle_cnt_r <= idle_cnt_r + 4'h1;
    end
  end
  assign idle_det = tick && rx_ovs_r == SRX_OVS_LAST && rx_st_r == SRX_IDLE && rx_line && rx_en
                    && idle_cnt_r == (long_w ? 4'hA : 4'h9);

  // Address mark is the data MSB, below the parity bit when parity is on
  wire addr_mark = long_w ? (par_en ? rx_w.data[7] : rx_w.data[8]) : (par_en ? rx_w.data[6] : rx_w.data[7]);
  wire wake_sel  = ctrl1_r[SRX_C1_WAKE];
  wire wake_idle = muted && !wake_sel && idle_det;
  wire wake_addr = muted && wake_sel && rx_done && addr_mark;
  wire rx_live   = rx_done && (!muted || wake_addr);           // Muted words are dropped
  wire to_hold   = rx_live && !status_r[SRX_ST_RXF];

  ////////////////////////////////////////////////////////////////////////
  // Transmitter
  srx_state_e tx_st_r;
  logic [3:0] tx_ovs_r, tx_bit_r;
  logic [8:0] tx_sh_r;
  logic       tx_is_pre_r, tx_done, tx_load, te_q_r;
  wire        tx_en = ctrl2_r[SRX_C2_TE];

  // Payload with MSB replaced by parity
  function automatic logic [8:0] tx_word(input logic [8:0] d, input logic lw, input logic pe, input logic odd);
    logic [8:0] w;
    w = d;
    if (pe && lw) w[8] = par_of(d, lw, odd);
    if (pe && !lw) w[7] = par_of(d, lw, odd);
    return w;
  endfunction : tx_word

  assign tx_load = tx_st_r == SRX_IDLE && tick && tx_en && te_q_r && tx_pend_r;  // Preamble goes first
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      tx_st_r     <= SRX_IDLE;
      tx_ovs_r    <= 4'h0;
      tx_bit_r    <= 4'h0;
      tx_sh_r     <= 9'h1FF;
      tx_line     <= 1'b1;
      tx_is_pre_r <= 1'b0;
      te_q_r      <= 1'b0;
    end else if (tick) begin
      te_q_r   <= tx_en;
      tx_ovs_r <= tx_ovs_r + 4'h1;
      case (tx_st_r)
        SRX_IDLE: begin
          tx_ovs_r <= 4'h0;
          tx_line  <= 1'b1;
          if (tx_en && !te_q_r) begin  // Enable sends an idle preamble
            tx_st_r     <= SRX_DATA;
            tx_is_pre_r <= 1'b1;
            tx_sh_r     <= 9'h1FF;
            tx_bit_r    <= 4'h0;
          end else if (tx_load) begin
            tx_st_r     <= SRX_START;
            tx_is_pre_r <= 1'b0;
            tx_sh_r     <= tx_word(tx_hold_r, long_w, par_en, par_odd);
            tx_bit_r    <= 4'h0;
            tx_line     <= 1'b0;
          end
        end
        SRX_START: if (tx_ovs_r == SRX_OVS_LAST) begin
          tx_st_r <= SRX_DATA;
          tx_line <= tx_sh_r[0];
        end
        SRX_DATA: if (tx_ovs_r == SRX_OVS_LAST) begin
          tx_sh_r  <= {1'b1, tx_sh_r[8:1]};
          tx_bit_r <= tx_bit_r + 4'h1;
          tx_line  <= (tx_bit_r + 4'h1 >= nbits) ? 1'b1 : tx_sh_r[1];
          if (tx_bit_r + 4'h1 == nbits) tx_st_r <= SRX_STOP;
        end
        SRX_STOP: if (tx_ovs_r == SRX_OVS_LAST) begin
          tx_st_r <= SRX_IDLE;
        end
        default: tx_st_r <= SRX_IDLE;
      endcase
    end
  end
  assign tx_done = tick && tx_st_r == SRX_STOP && tx_ovs_r == SRX_OVS_LAST && !tx_is_pre_r;

  ////////////////////////////////////////////////////////////////////////
  // Clear sequence: status read then data access clears flags seen set
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      st_seen_r <= 1'b0;
      st_snap_r <= 8'h00;
    end else if (st_rd) begin
      st_seen_r <= 1'b1;
      st_snap_r <= status_r;
    end else if (dat_rd || dat_wr) begin
      st_seen_r <= 1'b0;
    end
  end
  wire [7:0] clr_tx = (st_seen_r && dat_wr) ? (st_snap_r & status_r & 8'hC0) : 8'h00;
  wire [7:0] clr_rx = (st_seen_r && dat_rd) ? (st_snap_r & status_r & 8'h3F) : 8'h00;

  // Status flags; a setting event wins over the clear
  logic [7:0] set_v;
  always_comb begin
    set_v = 8'h00;
    set_v[SRX_ST_TXE]  = tx_load;
    set_v[SRX_ST_TC]   = tx_done;
    set_v[SRX_ST_RXF]  = to_hold;
    set_v[SRX_ST_IDLE] = !muted && idle_det && idle_arm_r;
    set_v[SRX_ST_OR]   = rx_live && status_r[SRX_ST_RXF];
    set_v[SRX_ST_NF]   = to_hold && rx_w.noise;
    set_v[SRX_ST_FE]   = to_hold && rx_w.frame_err;          // Overrun hides it
    set_v[SRX_ST_PE]   = to_hold && rx_w.par_err;
  end
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) status_r <= SRX_STATUS_RST;
    else if (!halt) status_r <= (status_r & ~(clr_tx | clr_rx)) | set_v;
  end

  // Idle flag re-arms only after a fresh word
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) idle_arm_r <= 1'b1;
    else if (to_hold) idle_arm_r <= 1'b1;
    else if (set_v[SRX_ST_IDLE] || wake_idle) idle_arm_r <= 1'b0;
  end

  // Holding buffer kept on overrun
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) rx_hold_r <= 9'h000;
    else if (to_hold) rx_hold_r <= rx_w.data;
  end

  // Transmit holding buffer
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      tx_hold_r <= 9'h000;
      tx_pend_r <= 1'b0;
    end else if (dat_wr) begin
      tx_hold_r <= {ctrl1_r[SRX_C1_T8], pwdata[7:0]};
      tx_pend_r <= 1'b1;
    end else if (tx_load) begin
      tx_pend_r <= 1'b0;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Control registers
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) ctrl1_r <= 8'h00;
    else if (to_hold) ctrl1_r[SRX_C1_R8] <= rx_w.data[8];
    else if (wr && paddr == SRX_OFF_CTRL1) ctrl1_r <= (ctrl1_r & ~SRX_C1_WMASK) | (pwdata[7:0] & SRX_C1_WMASK);
  end
  wire rwu_lock = wake_sel && status_r[SRX_ST_RXF];
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ctrl2_r <= 8'h00;
    end else if (wake_idle || wake_addr) begin
      ctrl2_r[SRX_C2_RWU] <= 1'b0;
    end else if (wr && paddr == SRX_OFF_CTRL2) begin
      ctrl2_r <= {pwdata[7:2], rwu_lock ? ctrl2_r[SRX_C2_RWU] : pwdata[1], pwdata[0]};
    end
  end
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) baud_r <= SRX_BAUD_RST;
    else if (wr && paddr == SRX_OFF_BAUD) baud_r <= pwdata[7:0];
  end
  // System register stays writable in halt so software can leave it
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) sys_r <= SRX_SYS_RST;
    else if (psel && penable && pwrite && paddr == SRX_OFF_SYS) sys_r <= pwdata[2:0];
  end

  ////////////////////////////////////////////////////////////////////////
  // Shared interrupt: receive sources silent while muted
  wire req = (status_r[SRX_ST_TXE] && ctrl2_r[SRX_C2_TIE])
          || (status_r[SRX_ST_TC] && ctrl2_r[SRX_C2_TX_DONE_IRQ_EN])
          || (!muted && (status_r[SRX_ST_RXF] || status_r[SRX_ST_OR]) && ctrl2_r[SRX_C2_RIE])
          || (!muted && status_r[SRX_ST_IDLE] && ctrl2_r[SRX_C2_QUIET_LINE_IRQ_EN])
          || (!muted && status_r[SRX_ST_PE] && ctrl1_r[SRX_C1_PIE]);
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      irq_r  <= 1'b0;
      wake_r <= 1'b0;
    end else begin
      irq_r  <= req && !sys_r[SRX_SY_MASK];
      wake_r <= req && sys_r[SRX_SY_WAIT] && !halt;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // APB: zero wait states, error on offsets above the system register
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata  <= 32'h0000_0000;
      pready  <= 1'b0;
      pslverr <= 1'b0;
    end else begin
      pready  <= psel && !penable;
      pslverr <= psel && !penable && paddr > SRX_OFF_SYS;
      if (psel && !penable && !pwrite) begin
        case (paddr)
          SRX_OFF_STATUS: prdata <= {24'h0, status_r};
          SRX_OFF_DATA:   prdata <= {24'h0, rx_hold_r[7:0]};
          SRX_OFF_CTRL1:  prdata <= {24'h0, ctrl1_r};
          SRX_OFF_CTRL2:  prdata <= {24'h0, ctrl2_r};
          SRX_OFF_BAUD:   prdata <= {24'h0, baud_r};
          SRX_OFF_SYS:    prdata <= {29'h0, sys_r};
          default:        prdata <= 32'h0000_0000;
        endcase
      end
    end
  end
endmodule : srx_top

// [design/srx_pkg.sv]
/*
  Package for the serial receiver/transmitter block with mute, wake-up and parity:
  register offsets, field positions, reset values and frame timing.
  Assumes a 32-bit APB slave; each register sits in the low bits of an aligned word.
*/
package srx_pkg;
  // Register byte offsets
  localparam logic [7:0] SRX_OFF_STATUS = 8'h00;
  localparam logic [7:0] SRX_OFF_DATA   = 8'h04;
  localparam logic [7:0] SRX_OFF_CTRL1  = 8'h08;
  localparam logic [7:0] SRX_OFF_CTRL2  = 8'h0C;
  localparam logic [7:0] SRX_OFF_BAUD   = 8'h10;
  localparam logic [7:0] SRX_OFF_SYS    = 8'h14;
  // Status fields
  localparam int SRX_ST_TXE  = 7;
  localparam int SRX_ST_TC   = 6;
  localparam int SRX_ST_RXF  = 5;
  localparam int SRX_ST_IDLE = 4;
  localparam int SRX_ST_OR   = 3;
  localparam int SRX_ST_NF   = 2;
  localparam int SRX_ST_FE   = 1;
  localparam int SRX_ST_PE   = 0;
  localparam logic [7:0] SRX_STATUS_RST = 8'hC0;
  // Control one fields
  localparam int SRX_C1_R8   = 7;
  localparam int SRX_C1_T8   = 6;
  localparam int SRX_C1_LONG = 4;
  localparam int SRX_C1_WAKE = 3;
  localparam int SRX_C1_PCE  = 2;
  localparam int SRX_C1_PS   = 1;
  localparam int SRX_C1_PIE  = 0;
  localparam logic [7:0] SRX_C1_WMASK = 8'h5F;
  // Control two fields
  localparam int SRX_C2_TIE  = 7;
  localparam int SRX_C2_TX_DONE_IRQ_EN = 6;
  localparam int SRX_C2_RIE  = 5;
  localparam int SRX_C2_QUIET_LINE_IRQ_EN = 4;
  localparam int SRX_C2_TE   = 3;
  localparam int SRX_C2_RE   = 2;
  localparam int SRX_C2_RWU  = 1;
  // System register fields: global mask, wait, halt
  localparam int SRX_SY_MASK = 0;
  localparam int SRX_SY_WAIT = 1;
  localparam int SRX_SY_HALT = 2;
  localparam logic [2:0] SRX_SYS_RST = 3'h1;
  // Oversampling: 16 ticks a bit, sampled in the middle
  localparam logic [3:0] SRX_OVS_LAST = 4'hF;
  localparam logic [3:0] SRX_OVS_MID  = 4'h7;
  localparam logic [7:0] SRX_BAUD_RST = 8'h00;
  // Receiver and transmitter frame states
  typedef enum logic [1:0] {
    SRX_IDLE  = 2'b00,
    SRX_START = 2'b01,
    SRX_DATA  = 2'b10,
    SRX_STOP  = 2'b11
  } srx_state_e;
  // One received word and its quality
  typedef struct packed {
    logic [8:0] data;
    logic       noise;
    logic       frame_err;
    logic       par_err;
  } srx_word_s;
endpackage : srx_pkg

// [bench/srx_node_model.sv]
/*
  Remote serial node: frames words onto the receive line and decodes what the block transmits.
  Assumes callers invoke send_word just after a rising pclk edge; BIT_CYC matches 16*OVS_DIV.
*/
`timescale 1ns/1ps
module srx_node_model #(
  parameter int BIT_CYC = 16
) (
  // Clock
  input  wire logic       pclk,
  // Line pair
  output logic            rx_line,
  input  wire logic       tx_line,
  // Decoded transmit byte
  output logic [7:0]      tx_byte,
  output int              tx_count
);
  ////////////////////////////////////////////////////////////////////////////
  // Sender: start, n bits LSB first, stop
  task automatic send_word(input logic [9:0] bits, input int n);
    rx_line <= 1'b0;
    repeat (BIT_CYC) @(posedge pclk);
    for (int i = 0; i < n; i++) begin
      rx_line <= bits[i];
      repeat (BIT_CYC) @(posedge pclk);
    end
    rx_line <= 1'b1;
    repeat (BIT_CYC) @(posedge pclk);
  endtask : send_word
  ////////////////////////////////////////////////////////////////////////////
  // Decoder samples mid-bit, returns in the stop bit
  initial begin
    rx_line  = 1'b1;
    tx_count = 0;
    tx_byte  = 8'h00;
    forever begin
      @(posedge pclk);
      if (tx_line === 1'b0) begin
        repeat (BIT_CYC / 2) @(posedge pclk);
        for (int i = 0; i < 8; i++) begin
          repeat (BIT_CYC) @(posedge pclk);
          tx_byte[i] = tx_line;
        end
        repeat (BIT_CYC) @(posedge pclk);
        tx_count++;
      end
    end
  end
endmodule : srx_node_model

// [bench/srx_top_properties.sv]
/*
  Port-level checker for the serial block: APB answer timing, error response, reset status,
  interrupt mask and low-power wake gating. Assumes it is bound into srx_top.
*/
`timescale 1ns/1ps
module srx_top_properties
  import srx_pkg::*;
#(
  parameter int OVS_DIV = 4
) (
  // Clock and reset
  input wire logic        pclk,
  input wire logic        presetn,
  // APB
  input wire logic        psel,
  input wire logic        penable,
  input wire logic        pwrite,
  input wire logic [7:0]  paddr,
  input wire logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  input wire logic        pready,
  input wire logic        pslverr,
  // Line and CPU side
  input wire logic        rx_line,
  input wire logic        tx_line,
  input wire logic        irq_r,
  input wire logic        wake_r
);
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  logic [2:0] sys_r;
  logic       fresh_r;
  logic       acc;
  assign acc = psel && penable && pready;
  ////////////////////////////////////////////////////////////////////////////
  // Shadow of the system register, needed to know when masking must bite
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      sys_r <= 3'h1;
    end else if (acc && pwrite && paddr == SRX_OFF_SYS) begin
      sys_r <= pwdata[2:0];
    end
  end
  // High until the first completed access after reset
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      fresh_r <= 1'b1;
    end else if (acc) begin
      fresh_r <= 1'b0;
    end
  end
  ////////////////////////////////////////////////////////////////////////////
  a_ready_in_access: assert property (psel && penable |-> pready)
    else $error("pready missing in access cycle");
  a_ready_only_access: assert property (pready |-> psel && penable)
    else $error("pready outside access cycle");
  a_slverr_range: assert property (psel && penable && paddr > 8'h14 |-> pslverr)
    else $error("no error on unmapped address");
  a_slverr_none: assert property (psel && penable && paddr <= 8'h14 |-> !pslverr)
    else $error("error on mapped address");
  a_status_reset: assert property (fresh_r && psel && penable && !pwrite && paddr == SRX_OFF_STATUS
    |-> prdata[7:0] == 8'hC0) else $error("status reset value wrong");
  a_irq_masked: assert property (sys_r[0] && $past(sys_r[0]) |-> !irq_r)
    else $error("interrupt while globally masked");
  a_wake_no_wait: assert property (!sys_r[1] && !$past(sys_r[1]) |-> !wake_r)
    else $error("wake outside wait mode");
  a_wake_in_halt: assert property (sys_r[2] && $past(sys_r[2]) |-> !wake_r)
    else $error("wake from halt");
  a_halt_tx_frozen: assert property (sys_r[2] && $past(sys_r[2]) |-> $stable(tx_line))
    else $error("tx line moved in halt");
  a_tx_idle_reset: assert property (fresh_r |-> tx_line)
    else $error("tx line not idle after reset");
  ////////////////////////////////////////////////////////////////////////////
  c_slverr: cover property (psel && penable && pslverr);
  c_wake: cover property (wake_r);
  c_irq: cover property (irq_r && !sys_r[0]);
endmodule : srx_top_properties
bind srx_top srx_top_properties #(.OVS_DIV(OVS_DIV)) u_props (.pclk, .presetn, .psel, .penable, .pwrite,
  .paddr, .pwdata, .prdata, .pready, .pslverr, .rx_line, .tx_line, .irq_r, .wake_r);

// [bench/tb_srx_top.sv]
/*
  Self-checking bench for srx_top: APB tasks, node model, scenarios.
  Assumes OVS_DIV of 1, so one bit is 16 pclk cycles.
*/
`timescale 1ns/1ps
module tb_srx_top;
  import srx_pkg::*;
  localparam int BIT = 16;
  logic        pclk = 1'b0;
  logic        presetn = 1'b0;
  logic        psel = 1'b0;
  logic        penable = 1'b0;
  logic        pwrite = 1'b0;
  logic [7:0]  paddr = 8'h00;
  logic [31:0] pwdata = 32'h0;
  logic [31:0] prdata, rd_v;
  logic        pready, pslverr, rx_line, tx_line, irq_r, wake_r, last_err;
  logic [7:0]  tx_byte;
  int          tx_count, err_total = 0, tests_run = 0, n0;
  always #5 pclk = ~pclk;
  srx_top #(.OVS_DIV(1)) DUT (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready,
    .pslverr, .rx_line, .tx_line, .irq_r, .wake_r);
  srx_node_model #(.BIT_CYC(BIT)) node (.pclk, .rx_line, .tx_line, .tx_byte, .tx_count);
  ////////////////////////////////////////////////////////////////////////////
  task automatic complete_run();
    $display("checks %0d mismatches %0d", tests_run, err_total);
    if (err_total == 0 && tests_run > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask : complete_run
  task automatic check(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    tests_run++;
    if (seen !== exp) begin
      err_total++;
      $display("unexpected %s expected %h seen %h", nm, exp, seen);
    end
  endtask : check
  // One transfer, then an idle cycle; defaults read status
  task automatic apb(input logic wr = 1'b0, input logic [7:0] a = SRX_OFF_STATUS, input logic [31:0] d = 32'h0);
    int n;
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    n = 0;
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'b1 && n < 50);
    if (n >= 50) begin
      err_total++;
      complete_run();
    end
    rd_v = prdata;
    last_err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
  endtask : apb
  // Receive clear: status read, data read
  task automatic take(input logic [7:0] exp, input logic chk);
    apb();
    apb(1'b0, SRX_OFF_DATA);
    if (chk) check("rx_data", {24'h0, rd_v[7:0]}, {24'h0, exp});
  endtask : take
  // Bounded poll of one status bit
  task automatic poll(input int b);
    int n;
    n = 0;
    do begin
      apb();
      n++;
    end while (rd_v[b] !== 1'b1 && n < 200);
    if (n >= 200) begin
      err_total++;
      complete_run();
    end
  endtask : poll
  ////////////////////////////////////////////////////////////////////////////
  // Watchdog on the whole run
  initial begin
    repeat (90000) @(posedge pclk);
    err_total++;
    complete_run();
  end
  ////////////////////////////////////////////////////////////////////////////
  // Parity cases: ctrl1, frame, parity flag
  logic [7:0] p_c1 [4] = '{8'h04, 8'h04, 8'h06, 8'h06};
  logic [9:0] p_w  [4] = '{10'h0B5, 10'h035, 10'h0B5, 10'h035};
  logic       p_pe [4] = '{1'b1, 1'b0, 1'b0, 1'b1};
  // Tx cases: ctrl1, written, on wire
  logic [7:0] t_c1 [3] = '{8'h04, 8'h06, 8'h04};
  logic [7:0] t_wd [3] = '{8'h35, 8'h35, 8'hB5};
  logic [7:0] t_ex [3] = '{8'h35, 8'hB5, 8'h35};
  initial begin
    repeat (10) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    apb();
    check("status_rst", {24'h0, rd_v[7:0]}, 32'hC0);
    apb(1'b0, SRX_OFF_SYS);
    check("sys_rst", {29'h0, rd_v[2:0]}, 32'h1);
    apb(1'b0, 8'h18);
    check("unmapped_err", {31'h0, last_err}, 32'h1);
    apb(1'b1, SRX_OFF_CTRL2, 32'h24);
    apb(1'b1, SRX_OFF_SYS, 32'h0);
    // Reception, interrupt gating and wake
    node.send_word(10'h0A5, 8);
    poll(SRX_ST_RXF);
    check("irq_rx", {31'h0, irq_r}, 32'h1);
    apb(1'b1, SRX_OFF_SYS, 32'h2);
    @(posedge pclk);
    check("wake_wait", {31'h0, wake_r}, 32'h1);
    apb(1'b1, SRX_OFF_SYS, 32'h6);
    repeat (2) @(posedge pclk);
    check("wake_halt", {31'h0, wake_r}, 32'h0);
    apb(1'b1, SRX_OFF_SYS, 32'h1);
    repeat (2) @(posedge pclk);
    check("irq_masked", {31'h0, irq_r}, 32'h0);
    take(8'hA5, 1'b1);
    repeat (25 * BIT) @(posedge pclk);
    apb();
    check("idle_set", {31'h0, rd_v[SRX_ST_IDLE]}, 32'h1);
    take(8'h00, 1'b0);
    repeat (25 * BIT) @(posedge pclk);
    apb();
    check("idle_once", {26'h0, rd_v[5:0]}, 32'h0);
    // Overrun keeps the first word
    node.send_word(10'h05A, 8);
    node.send_word(10'h03C, 8);
    poll(SRX_ST_OR);
    check("or_rxf", {31'h0, rd_v[SRX_ST_RXF]}, 32'h1);
    take(8'h5A, 1'b1);
    // Even and odd parity checking
    for (int i = 0; i < 4; i++) begin
      apb(1'b1, SRX_OFF_CTRL1, {24'h0, p_c1[i]});
      node.send_word(p_w[i], 8);
      poll(SRX_ST_RXF);
      check("parity_flag", {31'h0, rd_v[SRX_ST_PE]}, {31'h0, p_pe[i]});
      take(8'h00, 1'b0);
    end
    repeat (25 * BIT) @(posedge pclk);
    take(8'h00, 1'b0);
    // Mute with idle-line wake
    apb(1'b1, SRX_OFF_CTRL1, 32'h0);
    apb(1'b1, SRX_OFF_CTRL2, 32'h26);
    node.send_word(10'h011, 8);
    apb(1'b0, SRX_OFF_CTRL2);
    check("mute_held", {31'h0, rd_v[SRX_C2_RWU]}, 32'h1);
    apb();
    check("mute_no_rxf", {31'h0, rd_v[SRX_ST_RXF]}, 32'h0);
    repeat (25 * BIT) @(posedge pclk);
    apb(1'b0, SRX_OFF_CTRL2);
    check("idle_wake", {31'h0, rd_v[SRX_C2_RWU]}, 32'h0);
    apb();
    check("wake_no_idle", {31'h0, rd_v[SRX_ST_IDLE]}, 32'h0);
    // Address-mark wake, mute writes ignored while full
    apb(1'b1, SRX_OFF_CTRL1, 32'h08);
    apb(1'b1, SRX_OFF_CTRL2, 32'h26);
    node.send_word(10'h022, 8);
    apb();
    check("mark_low", {31'h0, rd_v[SRX_ST_RXF]}, 32'h0);
    node.send_word(10'h083, 8);
    poll(SRX_ST_RXF);
    apb(1'b1, SRX_OFF_CTRL2, 32'h26);
    apb(1'b0, SRX_OFF_CTRL2);
    check("mark_wake", {31'h0, rd_v[SRX_C2_RWU]}, 32'h0);
    take(8'h83, 1'b1);
    // Address mark with parity: data MSB counts, parity bit does not
    apb(1'b1, SRX_OFF_CTRL1, 32'h0C);
    apb(1'b1, SRX_OFF_CTRL2, 32'h26);
    node.send_word(10'h081, 8);
    apb();
    check("mark_par", {31'h0, rd_v[SRX_ST_RXF]}, 32'h0);
    node.send_word(10'h041, 8);
    poll(SRX_ST_RXF);
    take(8'h00, 1'b0);
    // Transmit with parity replacing the MSB
    apb(1'b1, SRX_OFF_CTRL2, 32'h0C);
    for (int i = 0; i < 3; i++) begin
      apb(1'b1, SRX_OFF_CTRL1, {24'h0, t_c1[i]});
      apb();
      n0 = tx_count;
      apb(1'b1, SRX_OFF_DATA, {24'h0, t_wd[i]});
      for (int k = 0; k < 40 * BIT && tx_count == n0; k++) @(posedge pclk);
      check("tx_count", tx_count, n0 + 1);
      check("tx_byte", {24'h0, tx_byte}, {24'h0, t_ex[i]});
      poll(SRX_ST_TC);
    end
    complete_run();
  end
endmodule : tb_srx_top
